// file: hw/mrsr_regs.sv
// metering result and status register group with documented register port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - The voltage peak source field [26:24] marks phase A, B or C by bit 0, 1 or 2.
// - The voltage peak register holds the 24-bit absolute value of the largest voltage peak.
// - The aux peak source field [29:24] sets bit n for the aux channel n that made the peak.
// - The aux peak register holds the 24-bit absolute value of the largest aux peak.
// - Sign bit 4 shows the second pulse-output sum sign, set when negative.
// - Sign bit 3 shows the first pulse-output sum sign, set when negative.
// - Sign bits 0, 1, 2 show phase A, B, C active power sign, set when negative.
// - No-load bits 0/2/4 give A/B/C active and 1/3/5 their apparent idle state.
// - The checksum register shows the 16-bit configuration CRC in its low half.
// - Status bits 31..28 latch zero crossings of aux channels 5..2 and clear on write of one.
// - Status bit 13 latches whenever the configuration CRC changes value.
// - Status bit 11 latches when any phase's active energy enters or leaves no-load.
// - Status bit 12 latches when any phase's apparent energy enters or leaves no-load.
module mrsr_regs (
	input  wire logic                                 ref_clk_i,
	input  wire logic                                 rst_n_i,
	// register port from the host interface logic
	input  wire logic                                 reg_rd_i,
	input  wire logic                                 reg_wr_i,
	input  wire logic [mrsr_pkg::MRSR_ADDR_W-1:0]     reg_addr_i,
	input  wire logic [mrsr_pkg::MRSR_DATA_W-1:0]     reg_wdata_i,
	output var  logic [mrsr_pkg::MRSR_DATA_W-1:0]     reg_rdata_o,
	output var  logic                                 reg_rvalid_o,
	// results from the metering datapath
	input  wire logic                                 voltage_peak_capture_upd_i,
	input  wire logic [mrsr_pkg::MRSR_VOLTAGE_PEAK_CAPTURE_SRC_W-1:0] voltage_peak_source_i,
	input  wire logic [mrsr_pkg::MRSR_PEAK_MAG_W-1:0] voltage_peak_magnitude_i,
	input  wire logic                                 aux_peak_capture_upd_i,
	input  wire logic [mrsr_pkg::MRSR_AUX_SRC_W-1:0]  aux_peak_source_i,
	input  wire logic [mrsr_pkg::MRSR_PEAK_MAG_W-1:0] aux_peak_magnitude_i,
	input  wire logic                                 sign_upd_i,
	input  wire logic                                 pulse_two_sum_negative_i,
	input  wire logic                                 pulse_one_sum_negative_i,
	input  wire logic [2:0]                           phase_power_negative_i,
	input  wire logic [mrsr_pkg::MRSR_NOLOAD_W-1:0]   no_load_i,
	input  wire logic                                 crc_upd_i,
	input  wire logic [mrsr_pkg::MRSR_CRC_W-1:0]      config_checksum_value_i,
	input  wire logic [mrsr_pkg::MRSR_ZX_W-1:0]       aux_crossing_i
);
	import mrsr_pkg::*;

	typedef struct packed {
		logic [MRSR_VOLTAGE_PEAK_CAPTURE_SRC_W-1:0] voltage_peak_capture_src;
		logic [MRSR_PEAK_MAG_W-1:0]  voltage_peak_capture_mag;
		logic [MRSR_AUX_SRC_W-1:0]   aux_src;
		logic [MRSR_PEAK_MAG_W-1:0]  aux_mag;
		logic [4:0]                  sign;
		logic [MRSR_NOLOAD_W-1:0]    no_load;
		logic [MRSR_CRC_W-1:0]       crc;
		logic [MRSR_DATA_W-1:0]      rdata;
		logic                        rvalid;
	} mrsr_st_t;

	mrsr_st_t                st_reg;
	mrsr_st_t                st_next;
	logic [MRSR_ZX_W-1:0]    zx_flag;
	logic                    act_idle_flag;
	logic                    app_idle_flag;
	logic                    crc_flag;
	logic                    status_wr;
	logic [MRSR_DATA_W-1:0]  status_word;
	logic [MRSR_DATA_W-1:0]  rd_word;
	logic [MRSR_NOLOAD_W-1:0] idle_change;

	assign status_wr = reg_wr_i && (reg_addr_i == MRSR_OFF_STICKY_EVENT_STATUS_LOW);
	assign idle_change = no_load_i ^ st_reg.no_load;

	// one sticky cell per aux zero-crossing flag
	genvar gi;
	generate
		for (gi = 0; gi < MRSR_ZX_W; gi++) begin : g_zx
			mrsr_sticky_bit u_zx (
				.ref_clk_i (ref_clk_i),
				.rst_n_i   (rst_n_i),
				.set_i     (aux_crossing_i[gi]),
				.clear_i   (status_wr && reg_wdata_i[MRSR_ST_ZX_LSB+gi]),
				.flag_o    (zx_flag[gi])
			);
		end
	endgenerate

	// idle edges compare with the stored copy, so a change is seen once
	mrsr_sticky_bit u_act_idle (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.set_i     (|{idle_change[4], idle_change[2], idle_change[0]}),
		.clear_i   (status_wr && reg_wdata_i[MRSR_ST_ACT_IDLE_BIT]),
		.flag_o    (act_idle_flag)
	);

	mrsr_sticky_bit u_app_idle (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.set_i     (|{idle_change[5], idle_change[3], idle_change[1]}),
		.clear_i   (status_wr && reg_wdata_i[MRSR_ST_APP_IDLE_BIT]),
		.flag_o    (app_idle_flag)
	);

	mrsr_sticky_bit u_config_checksum_changed (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.set_i     (crc_upd_i && (config_checksum_value_i != st_reg.crc)),
		.clear_i   (status_wr && reg_wdata_i[MRSR_ST_CONFIG_CHECKSUM_CHANGED_BIT]),
		.flag_o    (crc_flag)
	);

	always_comb begin
		status_word = '0;
		status_word[MRSR_ST_ZX_LSB +: MRSR_ZX_W] = zx_flag;
		status_word[MRSR_ST_ACT_IDLE_BIT] = act_idle_flag;
		status_word[MRSR_ST_APP_IDLE_BIT] = app_idle_flag;
		status_word[MRSR_ST_CONFIG_CHECKSUM_CHANGED_BIT] = crc_flag;
	end

	always_comb begin
		rd_word = '0;
		case (reg_addr_i)
			MRSR_OFF_VOLTAGE_PEAK_CAPTURE: begin
				rd_word[MRSR_PEAK_SRC_LSB +: MRSR_VOLTAGE_PEAK_CAPTURE_SRC_W] = st_reg.voltage_peak_capture_src;
				rd_word[MRSR_PEAK_MAG_LSB +: MRSR_PEAK_MAG_W] = st_reg.voltage_peak_capture_mag;
			end
			MRSR_OFF_AUX_PEAK_CAPTURE: begin
				rd_word[MRSR_PEAK_SRC_LSB +: MRSR_AUX_SRC_W] = st_reg.aux_src;
				rd_word[MRSR_PEAK_MAG_LSB +: MRSR_PEAK_MAG_W] = st_reg.aux_mag;
			end
			MRSR_OFF_SIGN: begin
				rd_word[4:0] = st_reg.sign;
			end
			MRSR_OFF_NOLOAD: begin
				rd_word[MRSR_NOLOAD_W-1:0] = st_reg.no_load;
			end
			MRSR_OFF_CRC: begin
				rd_word[MRSR_CRC_W-1:0] = st_reg.crc;
			end
			MRSR_OFF_STICKY_EVENT_STATUS_LOW: begin
				rd_word = status_word;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// host writes never reach the result fields: they load only from the datapath
	always_comb begin
		st_next = st_reg;
		if (voltage_peak_capture_upd_i) begin
			st_next.voltage_peak_capture_src = voltage_peak_source_i;
			st_next.voltage_peak_capture_mag = voltage_peak_magnitude_i;
		end
		if (aux_peak_capture_upd_i) begin
			st_next.aux_src = aux_peak_source_i;
			st_next.aux_mag = aux_peak_magnitude_i;
		end
		if (sign_upd_i) begin
			st_next.sign[MRSR_SIGN_SUM2_BIT] = pulse_two_sum_negative_i;
			st_next.sign[MRSR_SIGN_SUM1_BIT] = pulse_one_sum_negative_i;
			st_next.sign[MRSR_SIGN_PHASE_LSB +: 3] = phase_power_negative_i;
		end
		st_next.no_load = no_load_i;
		if (crc_upd_i) begin
			st_next.crc = config_checksum_value_i;
		end
		st_next.rvalid = reg_rd_i;
		st_next.rdata = reg_rd_i ? rd_word : st_reg.rdata;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o = st_reg.rdata;
	assign reg_rvalid_o = st_reg.rvalid;
endmodule : mrsr_regs
`default_nettype wire

// file: hw/mrsr_pkg.sv
// package: register map, field layout and reset values of the metering result/status group
package mrsr_pkg;
	localparam int          MRSR_ADDR_W          = 16;
	localparam int          MRSR_DATA_W          = 32;
	// voltage peak has no printed offset in this map; it sits just below the aux peak
	localparam logic [15:0] MRSR_OFF_VOLTAGE_PEAK_CAPTURE       = 16'h0286;
	localparam logic [15:0] MRSR_OFF_AUX_PEAK_CAPTURE     = 16'h0287;
	localparam logic [15:0] MRSR_OFF_SIGN        = 16'h0288;
	localparam logic [15:0] MRSR_OFF_NOLOAD      = 16'h0289;
	localparam logic [15:0] MRSR_OFF_CRC         = 16'h0295;
	localparam logic [15:0] MRSR_OFF_STICKY_EVENT_STATUS_LOW     = 16'h0400;
	localparam int          MRSR_PEAK_MAG_LSB    = 0;
	localparam int          MRSR_PEAK_MAG_W      = 24;
	localparam int          MRSR_PEAK_SRC_LSB    = 24;
	localparam int          MRSR_VOLTAGE_PEAK_CAPTURE_SRC_W     = 3;
	localparam int          MRSR_AUX_SRC_W       = 6;
	localparam int          MRSR_SIGN_PHASE_LSB  = 0;
	localparam int          MRSR_SIGN_SUM1_BIT   = 3;
	localparam int          MRSR_SIGN_SUM2_BIT   = 4;
	localparam int          MRSR_NOLOAD_W        = 6;
	localparam int          MRSR_CRC_W           = 16;
	localparam int          MRSR_ST_ACT_IDLE_BIT = 11;
	localparam int          MRSR_ST_APP_IDLE_BIT = 12;
	localparam int          MRSR_ST_CONFIG_CHECKSUM_CHANGED_BIT  = 13;
	localparam int          MRSR_ST_ZX_LSB       = 28;
	localparam int          MRSR_ZX_W            = 4;
	localparam logic [31:0] MRSR_RESET_VALUE     = 32'h0000_0000;
endpackage : mrsr_pkg

// file: hw/mrsr_sticky_bit.sv
// one sticky event flag: hardware set wins over host write-1-to-clear
`timescale 1ns/1ps
`default_nettype none
module mrsr_sticky_bit (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic set_i,
	input  wire logic clear_i,
	output var  logic flag_o
);
	import mrsr_pkg::*;

	typedef struct packed {
		logic flag;
	} mrsr_sticky_st_t;

	mrsr_sticky_st_t st_reg;
	mrsr_sticky_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (clear_i) begin
			st_next.flag = 1'b0;
		end
		// set after clear so a same-cycle event is kept
		if (set_i) begin
			st_next.flag = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign flag_o = st_reg.flag;
endmodule : mrsr_sticky_bit
`default_nettype wire

// file: dv/mrsr_regs_properties.sv
// checker: read-port field and timing properties of the register group
`timescale 1ns/1ps
`default_nettype none
module mrsr_regs_props (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        reg_rd_i,
	input wire logic        reg_wr_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic [5:0]  no_load_i,
	input wire logic        crc_upd_i,
	input wire logic [15:0] config_checksum_value_i,
	input wire logic [3:0]  aux_crossing_i
);
	import mrsr_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence rd_at(logic [15:0] a); reg_rd_i && reg_addr_i == a; endsequence
	// a quiet cycle between strobe and read, as the host model issues them
	sequence crc_then_rd; crc_upd_i ##1 !crc_upd_i ##1 rd_at(MRSR_OFF_CRC); endsequence
	// no write in between, so no legal clear can hide the flag
	sequence zx_then_rd; aux_crossing_i[3] ##1 !reg_wr_i ##1 rd_at(MRSR_OFF_STICKY_EVENT_STATUS_LOW); endsequence
	rvalid_pulse_a: assert property (reg_rvalid_o == $past(reg_rd_i))
		else $error("read valid not one cycle after request");
	voltage_peak_capture_rsvd_a: assert property (rd_at(MRSR_OFF_VOLTAGE_PEAK_CAPTURE) |=> reg_rdata_o[31:27] == '0)
		else $error("voltage_peak_capture reserved bits set");
	aux_rsvd_a: assert property (rd_at(MRSR_OFF_AUX_PEAK_CAPTURE) |=> reg_rdata_o[31:30] == '0)
		else $error("aux reserved bits set");
	sign_rsvd_a: assert property (rd_at(MRSR_OFF_SIGN) |=> reg_rdata_o[31:5] == '0)
		else $error("sign reserved bits set");
	noload_value_a: assert property (rd_at(MRSR_OFF_NOLOAD) |=>
		reg_rdata_o == {26'h0, $past(no_load_i, 2)}) else $error("no-load value wrong");
	crc_rsvd_a: assert property (rd_at(MRSR_OFF_CRC) |=> reg_rdata_o[31:16] == '0)
		else $error("crc reserved bits set");
	crc_value_a: assert property (crc_then_rd |=>
		reg_rdata_o[15:0] == $past(config_checksum_value_i, 3)) else $error("crc value wrong");
	status_rsvd_a: assert property (rd_at(MRSR_OFF_STICKY_EVENT_STATUS_LOW) |=>
		reg_rdata_o[27:14] == '0 && reg_rdata_o[10:0] == '0) else $error("status rsvd set");
	crossing_sticky_a: assert property (zx_then_rd |=> reg_rdata_o[31])
		else $error("crossing flag not set");
endmodule : mrsr_regs_props
bind mrsr_regs mrsr_regs_props chk_u (.ref_clk_i, .rst_n_i, .reg_rd_i, .reg_wr_i, .reg_addr_i,
	.reg_rdata_o, .reg_rvalid_o, .no_load_i, .crc_upd_i, .config_checksum_value_i,
	.aux_crossing_i);
`default_nettype wire

// file: dv/mrsr_host_model.sv
// host side model: issues single register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mrsr_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic [31:0] rdata_i,
	output var  logic        rd_o,
	output var  logic        wr_o,
	output var  logic [15:0] addr_o,
	output var  logic [31:0] wdata_o
);
	initial {rd_o, wr_o, addr_o, wdata_o} = '0;
	// idle bus shows inverted values so stale data never looks valid
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge ref_clk_i);
		{rd_o, addr_o} = {1'b1, a};
		@(negedge ref_clk_i);
		{rd_o, addr_o} = {1'b0, ~a};
		d = rdata_i;
	endtask : rd
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(negedge ref_clk_i);
		{wr_o, addr_o, wdata_o} = {1'b1, a, v};
		@(negedge ref_clk_i);
		{wr_o, addr_o, wdata_o} = {1'b0, ~a, ~v};
	endtask : wr
endmodule : mrsr_host_model
`default_nettype wire

// file: dv/metering_result_status_regs_test.sv
// self-checking bench for the metering result and status registers
`timescale 1ns/1ps
`default_nettype none
module metering_result_status_regs_test;
	import mrsr_pkg::*;
	logic        clk, rst_n, rd, wr, rv, vu, au, su, s2, s1, cu;
	logic [2:0]  vs, ph;
	logic [5:0]  as, nl;
	logic [23:0] vm, am;
	logic [15:0] addr, crc;
	logic [31:0] wd, rdat, got;
	logic [3:0]  zx;
	int          n_errors, num_checks, cyc;
	logic [15:0] offs [7] = '{MRSR_OFF_VOLTAGE_PEAK_CAPTURE, MRSR_OFF_AUX_PEAK_CAPTURE, MRSR_OFF_SIGN,
		MRSR_OFF_NOLOAD, MRSR_OFF_CRC, MRSR_OFF_STICKY_EVENT_STATUS_LOW, 16'h0290};
	mrsr_regs dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_rd_i(rd), .reg_wr_i(wr),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
		.voltage_peak_capture_upd_i(vu), .voltage_peak_source_i(vs), .voltage_peak_magnitude_i(vm),
		.aux_peak_capture_upd_i(au), .aux_peak_source_i(as), .aux_peak_magnitude_i(am),
		.sign_upd_i(su), .pulse_two_sum_negative_i(s2), .pulse_one_sum_negative_i(s1),
		.phase_power_negative_i(ph), .no_load_i(nl), .crc_upd_i(cu),
		.config_checksum_value_i(crc), .aux_crossing_i(zx));
	mrsr_host_model host_u (.ref_clk_i(clk), .rdata_i(rdat), .rd_o(rd), .wr_o(wr),
		.addr_o(addr), .wdata_o(wd));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic chk_reg(input logic [15:0] a, input logic [31:0] e);
		host_u.rd(a, got);
		check(got, e);
	endtask : chk_reg
	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		rst_n = 1'b0;
		{vu, au, su, s2, s1, cu, vs, ph, as, nl, vm, am, crc, zx} = '0;
		repeat (20) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		foreach (offs[i]) chk_reg(offs[i], 32'h0);
		@(negedge clk);
		{vs, vm, as, am} = {3'h4, 24'hABCDEF, 6'h20, 24'h123456};
		{s2, s1, ph, crc, nl} = {2'b10, 3'b011, 16'hBEEF, 6'h2D};
		{vu, au, su, cu} = 4'hF;
		@(negedge clk);
		// strobes dropped and vm, am, s2, ph cleared (vs, as, s1, crc unchanged): fields must keep the strobed values
		{vu, au, su, cu, vm, am, s2, ph} = '0;
		chk_reg(MRSR_OFF_VOLTAGE_PEAK_CAPTURE, 32'h04AB_CDEF);
		chk_reg(MRSR_OFF_AUX_PEAK_CAPTURE, 32'h2012_3456);
		chk_reg(MRSR_OFF_SIGN, 32'h0000_0013);
		chk_reg(MRSR_OFF_NOLOAD, 32'h0000_002D);
		chk_reg(MRSR_OFF_CRC, 32'h0000_BEEF);
		chk_reg(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h0000_3800);
		host_u.wr(MRSR_OFF_SIGN, 32'hFFFF_FFFF);
		chk_reg(MRSR_OFF_SIGN, 32'h0000_0013);
		host_u.wr(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'hFFFF_FFFF);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk) zx = 4'h1 << i;
			@(negedge clk) zx = 4'h0;
			repeat (5) @(negedge clk);
			chk_reg(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h1000_0000 << i);
			host_u.wr(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h1000_0000 << i);
			chk_reg(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h0);
		end
		@(negedge clk) zx = 4'h8;
		host_u.wr(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h8000_0000);
		zx = 4'h0;
		chk_reg(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h8000_0000);
		host_u.wr(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h8000_0000);
		@(negedge clk) cu = 1'b1;
		@(negedge clk) {cu, crc} = {1'b1, 16'h0001};
		@(negedge clk) cu = 1'b0;
		chk_reg(MRSR_OFF_CRC, 32'h0000_0001);
		chk_reg(MRSR_OFF_STICKY_EVENT_STATUS_LOW, 32'h0000_2000);
		// mid-run reset with loaded fields; no-load idle first so no edge follows release
		nl = '0;
		@(negedge clk) rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		foreach (offs[i]) chk_reg(offs[i], 32'h0);
		final_report();
	end
endmodule : metering_result_status_regs_test
`default_nettype wire
